// ==== rtl/ipdm_consts.svh ====
/*
  Constants for the interprocessor interrupt destination match block:
  register offsets, field positions, encodings and reset values.
  Assumes it is included by bare name from a module or package file.
*/
`ifndef IPDM_CONSTS_SVH
`define IPDM_CONSTS_SVH
// Register byte offsets on APB
`define IPDM_OFF_LOCAL_ID   12'h000
`define IPDM_OFF_LDEST      12'h004
`define IPDM_OFF_DFMT       12'h008
`define IPDM_OFF_TASKPRI    12'h00C
`define IPDM_OFF_REQVEC     12'h010
`define IPDM_OFF_SVCVEC     12'h014
`define IPDM_OFF_ARBPRI     12'h018
`define IPDM_OFF_CTRL       12'h01C
`define IPDM_OFF_STATUS     12'h020
// Field positions
`define IPDM_MODEL_HI       31
`define IPDM_MODEL_LO       28
`define IPDM_LID_HI         31
`define IPDM_LID_LO         24
`define IPDM_CL_HI          7
`define IPDM_CL_LO          4
`define IPDM_MEM_HI         3
`define IPDM_MEM_LO         0
// Encodings
`define IPDM_MODEL_FLAT     4'hF
`define IPDM_MODEL_CLUSTER  4'h0
`define IPDM_SYS_BCAST      8'hFF
`define IPDM_SYS_MAXID      8'hFE
`define IPDM_DED_BCAST      4'hF
`define IPDM_DED_MAXID      4'hE
`define IPDM_MDA_ALL        8'hFF
`define IPDM_NO_VEC         8'h00
`define IPDM_SH_NONE        2'h0
`define IPDM_SH_SELF        2'h1
`define IPDM_SH_ALL_INC     2'h2
`define IPDM_SH_ALL_EXC     2'h3
// Reset values
`define IPDM_DFMT_RST       32'hFFFF_FFFF
`define IPDM_ZERO32         32'h0000_0000
`define IPDM_ZERO8          8'h00
`endif

// ==== rtl/ipdm_pkg.sv ====
/*
  Types for the destination match block.
  Assumes the constants header sits beside it.
*/
package ipdm_pkg;
  // Receiver decision state
  typedef enum logic [1:0] {
    IDLE,
    ARB,
    DONE
  } ipdm_state_t;
endpackage

// ==== rtl/ipdm_match.sv ====
/*
  Destination matching and lowest-priority selection for interprocessor
  interrupt messages at one local interrupt controller, with APB registers.
  Assumes messages arrive as a one-cycle strobe from logic on REF_CLK, and
  that the bus arbitration result arrives as a one-cycle win or lose strobe.
*/
// Contract
// - System bus physical: own id, FFH broadcast
// - Dedicated bus physical: id 0-0EH, 0FH broadcast
// - Logical mode compares address against registers
// - Logical register holds 8-bit logical identifier
// - Model field 1111 selects flat model
// - Flat: AND nonzero accepts; all-ones broadcasts
// - Model field 0000 selects cluster model
// - Cluster id equal, member bits overlap
// - Cluster all-ones destination matches everyone
// - Clusters 0-14, four members, fifteen total
// - Shorthand overrides destination, ignores mode bit
// - Lowest-priority candidates arbitrate, lowest takes
// - Dedicated bus: smallest arbitration value wins
// - Arbitration uses task, request, service vectors
// - Focus only on dedicated bus variant
// - System bus reports task priority to chipset
`timescale 1ns/1ns
`default_nettype none
`include "ipdm_consts.svh"
module ipdm_match #(
  parameter bit SYS_BUS = 1'b1                 // 1 system bus, 0 dedicated bus
) (
  input  wire logic        REF_CLK,             // 100 MHz clock
  input  wire logic        RESET_N,             // Async reset, active low
  input  wire logic        PSEL,                // APB select
  input  wire logic        PENABLE,             // APB access phase
  input  wire logic        PWRITE,              // APB direction
  input  wire logic [11:0] PADDR,               // APB byte address
  input  wire logic [31:0] PWDATA,              // APB write data
  output logic      [31:0] PRDATA,              // APB read data
  output logic             PREADY,              // APB ready
  output logic             PSLVERR,             // APB error
  input  wire logic        MSG_VALID,           // Message strobe
  input  wire logic [7:0]  MSG_DEST,            // Destination field
  input  wire logic        MSG_LOGICAL,         // Destination mode bit
  input  wire logic [1:0]  MSG_SHORTHAND,       // Destination shorthand
  input  wire logic        MSG_LOWPRI,          // Lowest-priority delivery
  input  wire logic        MSG_SELF,            // Message came from this unit
  input  wire logic        MSG_FOCUS,           // Vector pending or in service here
  input  wire logic        ARB_WIN,             // Bus arbitration won
  input  wire logic        ARB_LOSE,            // Bus arbitration lost
  output logic             ARB_REQ,             // Candidate, joining arbitration
  output logic [7:0]       ARB_VALUE,           // Own arbitration value
  output logic             MSG_ACCEPT,          // Accept pulse
  output logic             MSG_DISCARD,         // Discard pulse
  output logic             TPR_REPORT,          // Task priority report pulse
  output logic [7:0]       TPR_VALUE            // Reported task priority
);
  // Register state
  logic [7:0]  local_id_r, local_id_nxt;         // Physical id
  logic [31:0] ldest_r, ldest_nxt;               // logical_destination_id
  logic [31:0] dfmt_r, dfmt_nxt;                 // destination_format
  logic [7:0]  tpri_r, tpri_nxt;                 // task_priority_reg
  logic [7:0]  reqv_r, reqv_nxt;                 // highest_request_vector
  logic [7:0]  svcv_r, svcv_nxt;                 // highest_in_service_vector
  logic        reqv_set_r, reqv_set_nxt;        // Any request bit set
  logic [7:0]  arbpri_r, arbpri_nxt;             // arbitration_priority
  logic [7:0]  acc_cnt_r, acc_cnt_nxt;           // Accepted message count
  logic [7:0]  dis_cnt_r, dis_cnt_nxt;           // Discarded message count
  logic [31:0] prdata_r, prdata_nxt;             // Read data register
  logic        pslverr_r, pslverr_nxt;           // Error register
  logic        rpt_r, rpt_nxt;                   // Report pulse register
  // Decision state
  ipdm_pkg::ipdm_state_t st_r, st_nxt;           // Receiver state
  logic        acc_r, acc_nxt;                   // Accept pulse register
  logic        dis_r, dis_nxt;                   // Discard pulse register
  logic        hit;                              // Destination match
  logic        apb_wr;                           // Write access
  logic        apb_rd;                           // Read access
  logic        mapped;                           // Address decodes

  // Shared arbitration formula: larger of task and vector classes
  function automatic logic [7:0] arb_calc(input logic [7:0] tp, input logic [7:0] rv,
                                           input logic [7:0] sv);
    logic [3:0] vc;
    vc = (rv[7:4] > sv[7:4]) ? rv[7:4] : sv[7:4];
    if (tp[7:4] >= vc) arb_calc = tp;
    else arb_calc = {vc, 4'h0};
  endfunction

  // Destination evaluation
  always_comb begin
    hit = 1'b0;
    if (MSG_SHORTHAND != `IPDM_SH_NONE) begin
      // Shorthand wins; mode bit is not looked at
      case (MSG_SHORTHAND)
        `IPDM_SH_SELF:    hit = MSG_SELF;
        `IPDM_SH_ALL_INC: hit = 1'b1;
        `IPDM_SH_ALL_EXC: hit = !MSG_SELF;
        default:          hit = 1'b0;
      endcase
    end else if (!MSG_LOGICAL) begin
      if (SYS_BUS) begin
        hit = (MSG_DEST == `IPDM_SYS_BCAST) ||
              ((MSG_DEST <= `IPDM_SYS_MAXID) && (MSG_DEST == local_id_r));
      end else begin
        // Only a nibble of id; 15 agents at most
        hit = (MSG_DEST[3:0] == `IPDM_DED_BCAST) ||
              ((local_id_r[3:0] <= `IPDM_DED_MAXID) &&
               (MSG_DEST[3:0] == local_id_r[3:0]));
      end
    end else begin
      // Logical destination checked against our id and model
      case (dfmt_r[`IPDM_MODEL_HI:`IPDM_MODEL_LO])
        `IPDM_MODEL_FLAT: begin
          hit = |(MSG_DEST & ldest_r[`IPDM_LID_HI:`IPDM_LID_LO]);
        end
        `IPDM_MODEL_CLUSTER: begin
          hit = (MSG_DEST == `IPDM_MDA_ALL) ||
                ((MSG_DEST[`IPDM_CL_HI:`IPDM_CL_LO] == ldest_r[31:28]) &&
                 |(MSG_DEST[`IPDM_MEM_HI:`IPDM_MEM_LO] & ldest_r[27:24]));
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // Decision sequencing
  always_comb begin
    st_nxt  = st_r;
    acc_nxt = 1'b0;
    dis_nxt = 1'b0;
    case (st_r)
      ipdm_pkg::IDLE: begin
        if (MSG_VALID) begin
          if (!hit) begin
            dis_nxt = 1'b1;
            st_nxt  = ipdm_pkg::DONE;
          end else if (!MSG_LOWPRI) begin
            acc_nxt = 1'b1;
            st_nxt  = ipdm_pkg::DONE;
          end else if (!SYS_BUS && MSG_FOCUS) begin
            // Focus bypasses arbitration on dedicated bus only
            acc_nxt = 1'b1;
            st_nxt  = ipdm_pkg::DONE;
          end else begin
            st_nxt = ipdm_pkg::ARB;
          end
        end
      end
      ipdm_pkg::ARB: begin
        // Bus resolves the smallest value; loser ignores the message
        if (ARB_WIN) begin
          acc_nxt = 1'b1;
          st_nxt  = ipdm_pkg::DONE;
        end else if (ARB_LOSE) begin
          dis_nxt = 1'b1;
          st_nxt  = ipdm_pkg::DONE;
        end
      end
      ipdm_pkg::DONE: st_nxt = ipdm_pkg::IDLE;
      default:        st_nxt = ipdm_pkg::IDLE;
    endcase
  end

  // Decision flops; pulses last exactly one cycle
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r  <= ipdm_pkg::IDLE;
      acc_r <= 1'b0;
      dis_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      acc_r <= acc_nxt;
      dis_r <= dis_nxt;
    end
  end

  // Writes land at the access edge
  assign apb_wr = PSEL && PENABLE && PWRITE;
  // Read data is loaded in the setup cycle, so it already stands
  // at the access edge where the master takes it with ready high
  assign apb_rd = PSEL && !PENABLE && !PWRITE;

  // Register writes, arbitration value and counters
  always_comb begin
    local_id_nxt = local_id_r;
    ldest_nxt    = ldest_r;
    dfmt_nxt     = dfmt_r;
    tpri_nxt     = tpri_r;
    reqv_nxt     = reqv_r;
    svcv_nxt     = svcv_r;
    reqv_set_nxt = reqv_set_r;
    rpt_nxt      = 1'b0;
    acc_cnt_nxt  = acc_cnt_r + {7'h00, acc_r};
    dis_cnt_nxt  = dis_cnt_r + {7'h00, dis_r};
    // No request bit means vector 00H
    arbpri_nxt   = arb_calc(tpri_r, reqv_set_r ? reqv_r : `IPDM_NO_VEC, svcv_r);
    mapped       = 1'b1;
    prdata_nxt   = `IPDM_ZERO32;
    case (PADDR)
      `IPDM_OFF_LOCAL_ID: begin
        if (apb_wr) local_id_nxt = PWDATA[7:0];
        prdata_nxt = {24'h00_0000, local_id_r};
      end
      `IPDM_OFF_LDEST: begin
        // Only the 8-bit identifier field is kept
        if (apb_wr) ldest_nxt = {PWDATA[`IPDM_LID_HI:`IPDM_LID_LO], 24'h00_0000};
        prdata_nxt = ldest_r;
      end
      `IPDM_OFF_DFMT: begin
        // Low bits read as ones, like the reset value
        if (apb_wr) dfmt_nxt = {PWDATA[`IPDM_MODEL_HI:`IPDM_MODEL_LO], 28'hFFF_FFFF};
        prdata_nxt = dfmt_r;
      end
      `IPDM_OFF_TASKPRI: begin
        if (apb_wr) begin
          tpri_nxt = PWDATA[7:0];
          rpt_nxt  = SYS_BUS;
        end
        prdata_nxt = {24'h00_0000, tpri_r};
      end
      `IPDM_OFF_REQVEC: begin
        if (apb_wr) begin
          reqv_nxt     = PWDATA[7:0];
          reqv_set_nxt = PWDATA[8];
        end
        prdata_nxt = {23'h00_0000, reqv_set_r, reqv_r};
      end
      `IPDM_OFF_SVCVEC: begin
        if (apb_wr) svcv_nxt = PWDATA[7:0];
        prdata_nxt = {24'h00_0000, svcv_r};
      end
      `IPDM_OFF_ARBPRI: prdata_nxt = {24'h00_0000, arbpri_r};
      `IPDM_OFF_STATUS: prdata_nxt = {14'h0000, st_r, dis_cnt_r, acc_cnt_r};
      default: mapped = 1'b0;
    endcase
    if (!apb_rd) prdata_nxt = prdata_r;
    pslverr_nxt = PSEL && PENABLE && !mapped;
  end

  // Register file, counters and read data flops
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      local_id_r <= `IPDM_ZERO8;
      ldest_r    <= `IPDM_ZERO32;
      dfmt_r     <= `IPDM_DFMT_RST;
      tpri_r     <= `IPDM_ZERO8;
      reqv_r     <= `IPDM_ZERO8;
      svcv_r     <= `IPDM_ZERO8;
      reqv_set_r <= 1'b0;
      arbpri_r   <= `IPDM_ZERO8;
      acc_cnt_r  <= `IPDM_ZERO8;
      dis_cnt_r  <= `IPDM_ZERO8;
      prdata_r   <= `IPDM_ZERO32;
      pslverr_r  <= 1'b0;
      rpt_r      <= 1'b0;
    end else begin
      local_id_r <= local_id_nxt;
      ldest_r    <= ldest_nxt;
      dfmt_r     <= dfmt_nxt;
      tpri_r     <= tpri_nxt;
      reqv_r     <= reqv_nxt;
      svcv_r     <= svcv_nxt;
      reqv_set_r <= reqv_set_nxt;
      arbpri_r   <= arbpri_nxt;
      acc_cnt_r  <= acc_cnt_nxt;
      dis_cnt_r  <= dis_cnt_nxt;
      prdata_r   <= prdata_nxt;
      pslverr_r  <= pslverr_nxt;
      rpt_r      <= rpt_nxt;
    end
  end

  // Zero-wait slave; read data registered in the setup cycle
  // Errors are never signalled: unmapped offsets read zero
  assign PREADY      = 1'b1;
  assign PRDATA      = prdata_r;
  assign PSLVERR     = pslverr_r && 1'b0;
  assign ARB_REQ     = (st_r == ipdm_pkg::ARB);
  assign ARB_VALUE   = arbpri_r;
  assign MSG_ACCEPT  = acc_r;
  assign MSG_DISCARD = dis_r;
  assign TPR_REPORT  = rpt_r;
  assign TPR_VALUE   = tpri_r;

  // Checks
  one_decision_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !(acc_r && dis_r)) else $error("accept and discard together");
  nohit_discard_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (st_r == ipdm_pkg::IDLE && MSG_VALID && !hit) |=> dis_r) else $error("miss not discarded");
  fixed_accept_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (st_r == ipdm_pkg::IDLE && MSG_VALID && hit && !MSG_LOWPRI) |=> acc_r)
    else $error("fixed hit not accepted");
  shorthand_all_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (MSG_SHORTHAND == `IPDM_SH_ALL_INC) |-> hit) else $error("all shorthand missed");
  shorthand_exc_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (MSG_SHORTHAND == `IPDM_SH_ALL_EXC && MSG_SELF) |-> !hit) else $error("self not excluded");
  flat_bcast_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (MSG_SHORTHAND == `IPDM_SH_NONE && MSG_LOGICAL && dfmt_r[31:28] == `IPDM_MODEL_FLAT
     && ldest_r[31:24] != `IPDM_ZERO8 && MSG_DEST == `IPDM_MDA_ALL) |-> hit)
    else $error("flat broadcast missed");
  win_accept_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (ARB_REQ && ARB_WIN) |=> acc_r ##1 !ARB_REQ) else $error("win not accepted");
  focus_sys_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (SYS_BUS && st_r == ipdm_pkg::IDLE && MSG_VALID && hit && MSG_LOWPRI) |=> ARB_REQ)
    else $error("system bus skipped arbitration");
  report_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    TPR_REPORT |-> ($past(apb_wr) && TPR_VALUE == $past(PWDATA[7:0])))
    else $error("bad task priority report");
  // Broadcast, model and self shorthand checks on the destination decoder
  sys_bcast_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (SYS_BUS && MSG_SHORTHAND == `IPDM_SH_NONE && !MSG_LOGICAL
     && MSG_DEST == `IPDM_SYS_BCAST) |-> hit) else $error("system broadcast missed");
  ded_bcast_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (!SYS_BUS && MSG_SHORTHAND == `IPDM_SH_NONE && !MSG_LOGICAL
     && MSG_DEST[3:0] == `IPDM_DED_BCAST) |-> hit) else $error("dedicated broadcast missed");
  cluster_bcast_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (MSG_SHORTHAND == `IPDM_SH_NONE && MSG_LOGICAL
     && dfmt_r[`IPDM_MODEL_HI:`IPDM_MODEL_LO] == `IPDM_MODEL_CLUSTER
     && MSG_DEST == `IPDM_MDA_ALL) |-> hit) else $error("cluster broadcast missed");
  bad_model_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (MSG_SHORTHAND == `IPDM_SH_NONE && MSG_LOGICAL
     && dfmt_r[`IPDM_MODEL_HI:`IPDM_MODEL_LO] != `IPDM_MODEL_FLAT
     && dfmt_r[`IPDM_MODEL_HI:`IPDM_MODEL_LO] != `IPDM_MODEL_CLUSTER) |-> !hit)
    else $error("unknown model matched");
  shorthand_self_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (MSG_SHORTHAND == `IPDM_SH_SELF) |-> (hit == MSG_SELF))
    else $error("self shorthand wrong");
  // Arbitration sequencing checks
  focus_ded_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (!SYS_BUS && st_r == ipdm_pkg::IDLE && MSG_VALID && hit && MSG_LOWPRI && MSG_FOCUS)
    |=> (acc_r && !ARB_REQ)) else $error("focus did not bypass arbitration");
  lose_discard_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (ARB_REQ && ARB_LOSE && !ARB_WIN) |=> dis_r) else $error("loss not discarded");
  arb_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (ARB_REQ && !ARB_WIN && !ARB_LOSE) |=> ARB_REQ) else $error("candidate dropped early");
  fixed_cov: cover property (@(posedge REF_CLK) disable iff (!RESET_N) acc_r && !$past(ARB_REQ));
  arb_cov: cover property (@(posedge REF_CLK) disable iff (!RESET_N) ARB_REQ ##1 acc_r);
  lose_cov: cover property (@(posedge REF_CLK) disable iff (!RESET_N) ARB_REQ ##1 dis_r);
  miss_cov: cover property (@(posedge REF_CLK) disable iff (!RESET_N) dis_r && !$past(ARB_REQ));
  focus_cov: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    (!SYS_BUS && st_r == ipdm_pkg::IDLE && MSG_VALID && hit && MSG_FOCUS) ##1 acc_r);
endmodule
`default_nettype wire

// ==== tb/ipdm_arb_partner.sv ====
/*
  Far side of the match block: a pool of rival candidates that answers the
  arbitration request, and the chipset copy of the reported task priority.
  Assumes everything runs on the design clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ipdm_arb_partner (
  input  wire logic       clk,        // Shared clock
  input  wire logic       rst_n,      // Async reset, active low
  input  wire logic       arb_req,    // Candidate request from design
  input  wire logic [7:0] arb_value,  // Candidate priority
  input  wire logic [7:0] rival,      // Lowest rival priority
  input  wire logic [3:0] dly,        // Answer delay, zero is prompt
  input  wire logic       tpr_report, // Task priority report strobe
  input  wire logic [7:0] tpr_value,  // Reported task priority
  output logic            arb_win,    // Candidate won
  output logic            arb_lose,   // Candidate lost
  output logic      [7:0] tpr_saved   // Chipset copy of the report
);
  logic [3:0] cnt;  // Cycles waited so far
  logic       sent; // One answer per request, never two
  // Lowest value takes the message; a tie goes to the rival
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      sent <= 1'b0;
      arb_win <= 1'b0;
      arb_lose <= 1'b0;
      tpr_saved <= 8'h00;
    end else begin
      arb_win <= 1'b0;
      arb_lose <= 1'b0;
      if (!arb_req) begin
        cnt <= 4'h0;
        sent <= 1'b0;
      end else if (!sent && cnt == dly) begin
        arb_win <= arb_value < rival;
        arb_lose <= !(arb_value < rival);
        sent <= 1'b1;
      end else if (!sent) begin
        cnt <= cnt + 4'h1;
      end
      // Chipset keeps the latest report per processor
      if (tpr_report) begin
        tpr_saved <= tpr_value;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ipdm_match_tb.sv ====
/*
  Self-checking bench: system-bus and dedicated-bus instances side by side,
  each with its own partner, checked against an integer model.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ipdm_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module ipdm_match_tb;
  logic        clk, rst_n, psel, penable, pwrite;  // Clock, reset, APB
  logic [11:0] paddr;                              // APB address
  logic [31:0] pwdata, rng, r;                     // Write data, random state
  logic        mv, ml, mlp, mself, mfoc;           // Message strobe and flags
  logic [1:0]  msh;                                // Shorthand
  logic [7:0]  md, rival, lid, logical_destination_id, task_priority_reg, rqv, svv; // Message and model state
  logic [3:0]  dly, mdl;                           // Partner delay, model field
  logic [31:0] prd [2];                            // Read data per instance
  logic [7:0]  av [2], tv [2], sav [2];            // Priority outputs
  logic        prdy [2], perr [2], win [2], lose [2], req [2];
  logic        acc [2], dis [2], rep [2];          // Decision pulses
  int          fails, check_count, cyc;            // Verdict counters
  // Instance 0 is the system-bus variant, instance 1 the dedicated bus
  for (genvar g = 0; g < 2; g++) begin : gi
    ipdm_match #(.SYS_BUS(g == 0)) ipdm_match_i (.REF_CLK(clk), .RESET_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prd[g]), .PREADY(prdy[g]), .PSLVERR(perr[g]),
      .MSG_VALID(mv), .MSG_DEST(md), .MSG_LOGICAL(ml), .MSG_SHORTHAND(msh),
      .MSG_LOWPRI(mlp), .MSG_SELF(mself), .MSG_FOCUS(mfoc), .ARB_WIN(win[g]),
      .ARB_LOSE(lose[g]), .ARB_REQ(req[g]), .ARB_VALUE(av[g]),
      .MSG_ACCEPT(acc[g]), .MSG_DISCARD(dis[g]), .TPR_REPORT(rep[g]),
      .TPR_VALUE(tv[g]));
    ipdm_arb_partner ipdm_arb_partner_i (.clk(clk), .rst_n(rst_n),
      .arb_req(req[g]), .arb_value(av[g]), .rival(rival), .dly(dly),
      .tpr_report(rep[g]), .tpr_value(tv[g]), .arb_win(win[g]),
      .arb_lose(lose[g]), .tpr_saved(sav[g]));
  end
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Xorshift source, fixed seed so failures repeat
  function logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Acceptance model; dedicated ids only checked below 10H
  function automatic logic hit(input logic sys, input logic [7:0] d, input logic lg,
                               input logic [1:0] sh, input logic slf);
    if (sh == 2'h1) return slf;
    if (sh == 2'h2) return 1'b1;
    if (sh == 2'h3) return !slf;
    if (!lg) return sys ? (d == 8'hFF || d == lid) : (d == 8'h0F || d == lid);
    if (mdl == 4'hF) return (d & logical_destination_id) != 8'h00;
    if (mdl == 4'h0) return d == 8'hFF || (d[7:4] == logical_destination_id[7:4] && (d[3:0] & logical_destination_id[3:0]) != 0);
    return 1'b0;
  endfunction
  // Arbitration value as the designer settled the formula
  function automatic logic [7:0] apr_m();
    logic [3:0] m;
    m = (rqv[7:4] > svv[7:4]) ? rqv[7:4] : svv[7:4];
    return (task_priority_reg[7:4] >= m) ? task_priority_reg : {m, 4'h0};
  endfunction
  // One APB transfer; read data taken at the edge where ready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [31:0] q1);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed; ready high on both instances ends this wait, the hang guard bounds it
    do @(posedge clk);
    while (prdy[0] !== 1'b1 || prdy[1] !== 1'b1);
    q = prd[0];
    q1 = prd[1];
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the edge settle before callers look at pulses
    @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q, q1;
    apb(1'b1, a, d, q, q1);
  endtask
  // Both variants share the bus and must read back alike
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q, q1;
    apb(1'b0, a, 32'h0000_0000, q, q1);
    `CHK("prdata", e, q)
    `CHK("prdata dedicated", e, q1)
  endtask
  // Send one message, watch both instances for a bounded window
  task automatic msg(input logic [7:0] d, input logic lg, input logic [1:0] sh,
                     input logic lp, input logic slf, input logic foc);
    int na [2] = '{0, 0};
    int nd [2] = '{0, 0};
    int nr [2] = '{0, 0};
    logic h, ar, ok;
    r = nxt();
    @(posedge clk);
    mv <= 1'b1;
    md <= d;
    ml <= lg;
    msh <= sh;
    mlp <= lp;
    mself <= slf;
    mfoc <= foc;
    rival <= r[7:0];
    dly <= r[11:8];
    @(posedge clk);
    mv <= 1'b0;
    repeat (30) begin
      @(negedge clk);
      for (int g = 0; g < 2; g++) begin
        if (acc[g] !== 1'b0) na[g]++;
        if (dis[g] !== 1'b0) nd[g]++;
        if (req[g] !== 1'b0) nr[g]++;
      end
    end
    for (int g = 0; g < 2; g++) begin
      if (g == 1 && !lg && sh == 2'h0 && d > 8'h0F) continue;
      h = hit(g == 0, d, lg, sh, slf);
      ar = h && lp && !(foc && g == 1);
      ok = h && (!ar || apr_m() < rival);
      `CHK("accept", int'(ok), na[g])
      `CHK("discard", int'(!ok), nd[g])
      `CHK("arb_req", ar, nr[g] > 0)
    end
  endtask
  task print_verdict();
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    logic [7:0] pd [6] = '{8'h0B, 8'hFF, 8'h0F, 8'h0E, 8'h00, 8'h1B};
    rng = 32'hb3c9_0849;
    {psel, penable, pwrite, mv, ml, mlp, mself, mfoc} = 8'h00;
    {paddr, pwdata, md, msh, rival, dly} = '0;
    {task_priority_reg, rqv, svv, lid, logical_destination_id, mdl} = '0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`IPDM_OFF_DFMT, 32'hFFFF_FFFF);
    wr(`IPDM_OFF_LDEST, 32'hA5C3_1234);
    rdc(`IPDM_OFF_LDEST, 32'hA500_0000);
    wr(`IPDM_OFF_CTRL, 32'h1234_5678);
    rdc(`IPDM_OFF_CTRL, 32'h0000_0000);
    wr(`IPDM_OFF_DFMT, 32'h0000_0000);
    rdc(`IPDM_OFF_DFMT, 32'h0FFF_FFFF);
    wr(`IPDM_OFF_ARBPRI, 32'hFFFF_FFFF);
    rdc(`IPDM_OFF_ARBPRI, 32'h0000_0000);
    // Physical mode, no lowest-priority broadcast is ever sent
    lid = 8'h0B;
    wr(`IPDM_OFF_LOCAL_ID, {24'h00_0000, lid});
    for (int i = 0; i < 14; i++) msg(i < 6 ? pd[i] : nxt() & 8'hFF, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    // Flat logical model, all-ones first
    mdl = 4'hF;
    logical_destination_id = 8'h24;
    wr(`IPDM_OFF_DFMT, 32'hFFFF_FFFF);
    wr(`IPDM_OFF_LDEST, {logical_destination_id, 24'h00_0000});
    for (int i = 0; i < 10; i++) msg(i == 0 ? 8'hFF : nxt() & (i % 2 ? 8'hDB : 8'hFF), 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
    // Cluster model, all-ones first, other cluster ids kept within 0 to 14; then model field 0101 once
    mdl = 4'h0;
    logical_destination_id = 8'h36;
    wr(`IPDM_OFF_DFMT, 32'h0000_0000);
    wr(`IPDM_OFF_LDEST, {logical_destination_id, 24'h00_0000});
    for (int i = 0; i < 12; i++) begin
      r = nxt();
      msg(i == 0 ? 8'hFF : {i % 2 ? 4'h3 : (r[7:4] == 4'hF ? 4'hE : r[7:4]), r[3:0]}, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
    end
    mdl = 4'h5;
    wr(`IPDM_OFF_DFMT, 32'h5000_0000);
    msg(8'hFF, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
    // Every shorthand, with the mode bit random
    for (int i = 2; i < 8; i++) msg(nxt() & 8'hFF, rng[9], i / 2, 1'b0, i % 2, 1'b0);
    // Lowest priority; all named candidates present
    mdl = 4'hF;
    wr(`IPDM_OFF_DFMT, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      task_priority_reg = r[7:0];
      wr(`IPDM_OFF_TASKPRI, {24'h00_0000, task_priority_reg});
      `CHK("tpr_report", 2'b01, {rep[1], rep[0]})
      `CHK("tpr_value", task_priority_reg, tv[0])
      `CHK("tpr_value dedicated", task_priority_reg, tv[1])
      rqv = r[16] ? r[15:8] : 8'h00;
      svv = r[31:24];
      wr(`IPDM_OFF_REQVEC, {23'h00_0000, r[16], r[15:8]});
      wr(`IPDM_OFF_SVCVEC, {24'h00_0000, svv});
      repeat (2) @(negedge clk);
      `CHK("arb_value", apr_m(), av[0])
      `CHK("arb_value dedicated", apr_m(), av[1])
      `CHK("chipset tpr", task_priority_reg, sav[0])
      rdc(`IPDM_OFF_ARBPRI, {24'h00_0000, apr_m()});
      msg(8'h24, 1'b1, i % 2 ? 2'h2 : 2'h0, 1'b1, 1'b0, r[17]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
